// file: rtl/rsfl_pkg.sv
// Constants for the reset source and reset cause flag block.
// Assumes one 100 MHz core clock and word-aligned AHB-Lite register access.
package rsfl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] IDX_RESET_STATUS = 8'h96;
    localparam logic [7:0] IDX_CHIP_CONTROL = 8'h9F;
    localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hAA;
    localparam logic [7:0] IDX_POWER_MONITOR = 8'hAC;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;

    // power_control fields
    localparam int SERIAL_BAUD_DOUBLER_BIT = 7;
    localparam int COLD_RESET_FLAG_BIT = 4;
    localparam int GENERAL_FLAG_ONE_BIT = 3;
    localparam int GENERAL_FLAG_ZERO_BIT = 2;
    // reset_status fields
    localparam int BROWNOUT_RESET_CAUSE_FLAG_BIT = 2;
    localparam int SOFT_RESET_CAUSE_FLAG_BIT = 0;
    // watchdog_control fields
    localparam int WATCHDOG_RUN_ENABLE_BIT = 7;
    localparam int WATCHDOG_CLEAR_BIT = 6;
    localparam int WATCHDOG_IN_POWERDOWN_BIT = 4;
    localparam int WATCHDOG_RESET_CAUSE_FLAG_BIT = 3;
    localparam int WATCHDOG_PRESCALE_MSB = 2;
    // power_monitor_register and chip control fields
    localparam int BROWNOUT_RESET_ENABLE_BIT = 4;
    localparam int SOFT_RESET_TRIGGER_BIT = 7;

    // Interrupt status and mask layout
    localparam int IRQ_WIDTH = 5;
    localparam int IRQ_SOFT_BIT = 0;
    localparam int IRQ_PIN_BIT = 1;
    localparam int IRQ_WATCHDOG_BIT = 2;
    localparam int IRQ_BROWNOUT_BIT = 3;
    localparam int IRQ_COLD_BIT = 4;

    // Reset values
    localparam logic BROWNOUT_RESET_ENABLE_RST = 1'b1;
    localparam logic [2:0] WATCHDOG_PRESCALE_RST = 3'h0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RST = 5'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // Timing: one machine cycle is twelve core clocks
    localparam int MACHINE_CYCLE_CLKS = 12;
    localparam int WATCHDOG_HOLD_MCYC = 2;
    localparam int SOFT_HOLD_MCYC = 2;
    localparam int CNT_WIDTH = 8;
    localparam logic [CNT_WIDTH-1:0] WATCHDOG_HOLD_CLKS =
        CNT_WIDTH'(WATCHDOG_HOLD_MCYC * MACHINE_CYCLE_CLKS);
    localparam logic [CNT_WIDTH-1:0] SOFT_HOLD_CLKS =
        CNT_WIDTH'(SOFT_HOLD_MCYC * MACHINE_CYCLE_CLKS);
    localparam logic [CNT_WIDTH-1:0] OSC_START_CLKS = 8'h40;
    localparam logic [CNT_WIDTH-1:0] CNT_ONE = 8'h01;

    // Number of pin and detector levels that pass the synchroniser
    localparam int SYNC_WIDTH = 3;
    localparam int SYNC_PIN = 0;
    localparam int SYNC_SUPPLY = 1;
    localparam int SYNC_BROWNOUT = 2;

    typedef enum logic [1:0] {
        ST_POWER_ON,
        ST_OSC_START,
        ST_RUN,
        ST_HOLD
    } rsfl_state_t;
endpackage

// file: rtl/rsfl_in_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous levels.
// Assumes inputs come from pins or analog detectors outside core_clk.
`timescale 1ns/1ps
module rsfl_in_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Output follows only once the last two stages agree
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else begin
                    stage1[i] <= asyncIn[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        syncOut[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// file: rtl/rsfl_reset_flags.sv
// Reset source sequencer and reset cause flags, AHB-Lite register slave.
// Assumes rst is the cold power-on reset; watchdog time-out comes from
// core_clk logic; pin and detector levels are asynchronous.
//
// Contract
// [R1] Five sources (power-on, pin, software, watchdog, brown-out) drive system reset.
// [R2] Any reset returns control bits to reset values; only cause flags differ; irqMask is kept, reset only by rst.
// [R3] Cold-reset flag, power_control bit 4, set when power-on reset completes.
// [R4] Cold-reset flag unchanged by every non power-on reset.
// [R5] Brown-out cause flag, reset_status bit 2, set by hardware on brown-out reset.
// [R6] Brown-out flag kept through warm resets; software clears it writing zero.
// [R7] Soft cause flag, reset_status bit 0, set on software reset; writable.
// [R8] Watchdog cause flag, watchdog_control bit 3, set on watchdog reset.
// [R9] Hold power-on reset while supply is below reference; no fetches.
// [R10] After power-on, start oscillator, then run from vector 0000H, set flag.
// [R11] Brown-out resets the processor only when its enable bit 4 is one.
// [R12] External party holds the reset pin high at least two machine cycles.
// [R13] Software clears cold flag; later power cycle shows one, warm keeps zero.
// [R14] Internal RAM is not initialised on power-on.
// [R15] Pin reset is synchronous, lasts while pin high, records no flag; code still sets irqStatus bit 1 on it.
// [R16] Watchdog time-out holds system reset for two machine cycles.
// [R17] Watchdog cause flag survives warm resets; power-on clears it.
// [R18] Writing one to soft trigger resets; hardware clears trigger when done.
// [R19] Concurrent sources all flag; power-on wins and clears warm flags.
`timescale 1ns/1ps
module rsfl_reset_flags (
    // Clock and cold reset
    input wire logic core_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Reset sources
    input wire logic resetPin,
    input wire logic supplyBelowRef,
    input wire logic brownoutDetect,
    input wire logic watchdogTimeout,
    // Towards the processor and watchdog
    output logic sysReset,
    output logic oscEnable,
    output logic [15:0] resetVector,
    output logic watchdogRunEnable,
    output logic watchdogInPowerdown,
    output logic [2:0] watchdogPrescale,
    output logic watchdogClear,
    output logic serialBaudDoubler,
    // Interrupt
    output logic irq
);
    rsfl_pkg::rsfl_state_t state;
    rsfl_pkg::rsfl_state_t next_state;
    logic [rsfl_pkg::CNT_WIDTH-1:0] holdCnt;
    logic [rsfl_pkg::CNT_WIDTH-1:0] next_holdCnt;
    logic [rsfl_pkg::SYNC_WIDTH-1:0] syncLevels;
    logic coldResetFlag;
    logic brownoutResetCauseFlag;
    logic softResetCauseFlag;
    logic watchdogResetCauseFlag;
    logic softResetTrigger;
    logic brownoutResetEnable;
    logic generalFlagOne;
    logic generalFlagZero;
    logic [rsfl_pkg::IRQ_WIDTH-1:0] irqStatus;
    logic [rsfl_pkg::IRQ_WIDTH-1:0] irqMask;
    logic wrPend;
    logic [7:0] wrIdx;

    function automatic logic regHit(input logic [7:0] idx,
                                    input logic [7:0] reg_idx);
        regHit = (idx == reg_idx);
    endfunction

    // Pin and detector levels cross into core_clk
    rsfl_in_sync #(
        .WIDTH(rsfl_pkg::SYNC_WIDTH)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn({brownoutDetect, supplyBelowRef, resetPin}),
        .syncOut(syncLevels)
    );

    wire pinHigh = syncLevels[rsfl_pkg::SYNC_PIN];
    wire supplyLow = syncLevels[rsfl_pkg::SYNC_SUPPLY];
    wire brownLow = syncLevels[rsfl_pkg::SYNC_BROWNOUT];
    wire active = (state == rsfl_pkg::ST_RUN) ||
                  (state == rsfl_pkg::ST_HOLD);
    wire inPowerOn = (state == rsfl_pkg::ST_POWER_ON) || supplyLow;

    // Source events, seen only while the supply is good
    // [R11] Brown-out gated by enable
    wire borEvt = active && !supplyLow && brownLow && brownoutResetEnable;
    // [R15] Pin reset taken synchronously
    wire pinEvt = active && !supplyLow && pinHigh;
    wire wdtEvt = active && !supplyLow && watchdogTimeout;
    wire swEvt = (state == rsfl_pkg::ST_RUN) && !supplyLow &&
                 softResetTrigger;
    wire anyEvt = borEvt || pinEvt || wdtEvt || swEvt;
    wire holdDone = (holdCnt <= rsfl_pkg::CNT_ONE) && !pinHigh && !borEvt;
    wire oscDone = (holdCnt <= rsfl_pkg::CNT_ONE);

    // [R16] Watchdog hold length
    wire [rsfl_pkg::CNT_WIDTH-1:0] wdtLoad =
        wdtEvt ? rsfl_pkg::WATCHDOG_HOLD_CLKS : rsfl_pkg::CNT_ONE;
    wire [rsfl_pkg::CNT_WIDTH-1:0] swLoad =
        swEvt ? rsfl_pkg::SOFT_HOLD_CLKS : rsfl_pkg::CNT_ONE;
    wire [rsfl_pkg::CNT_WIDTH-1:0] evtLoad =
        (wdtLoad > swLoad) ? wdtLoad : swLoad;
    wire [rsfl_pkg::CNT_WIDTH-1:0] holdDec =
        (holdCnt > rsfl_pkg::CNT_ONE) ? holdCnt - rsfl_pkg::CNT_ONE : holdCnt;

    // [R1] Sequencer merging all sources into one system reset
    always_comb begin
        next_state = state;
        next_holdCnt = holdDec;
        case (state)
            rsfl_pkg::ST_POWER_ON: begin
                next_holdCnt = rsfl_pkg::OSC_START_CLKS;
                // [R9] Held while supply low
                if (!supplyLow) begin
                    next_state = rsfl_pkg::ST_OSC_START;
                end
            end
            rsfl_pkg::ST_OSC_START: begin
                // [R10] Oscillator first, then run
                if (oscDone) begin
                    next_state = rsfl_pkg::ST_RUN;
                end
            end
            rsfl_pkg::ST_RUN: begin
                if (anyEvt) begin
                    next_state = rsfl_pkg::ST_HOLD;
                    next_holdCnt = evtLoad;
                end
            end
            rsfl_pkg::ST_HOLD: begin
                if (wdtEvt && holdDec < evtLoad) begin
                    next_holdCnt = evtLoad;
                end else if (holdDone) begin
                    next_state = rsfl_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = rsfl_pkg::ST_POWER_ON;
            end
        endcase
        // [R19] Power-on overrides every other source
        if (supplyLow) begin
            next_state = rsfl_pkg::ST_POWER_ON;
        end
    end

    wire leavingReset = (next_state == rsfl_pkg::ST_RUN) &&
                        (state != rsfl_pkg::ST_RUN);
    wire coldDone = (state == rsfl_pkg::ST_OSC_START) && leavingReset;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= rsfl_pkg::ST_POWER_ON;
            holdCnt <= rsfl_pkg::OSC_START_CLKS;
        end else begin
            state <= next_state;
            holdCnt <= next_holdCnt;
        end
    end

    // System reset and oscillator straight from flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sysReset <= 1'b1;
            oscEnable <= 1'b0;
            resetVector <= rsfl_pkg::RESET_VECTOR;
        end else begin
            sysReset <= (next_state != rsfl_pkg::ST_RUN);
            oscEnable <= (next_state != rsfl_pkg::ST_POWER_ON);
            resetVector <= rsfl_pkg::RESET_VECTOR;
        end
    end

    // AHB-Lite: address phase latched, zero wait states
    wire take = hsel && htrans[1] && hready;
    wire [7:0] addrIdx = haddr[9:2];
    wire addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    wire rdTake = take && !hwrite && addrOk;
    wire [7:0] wrData = hwdata[7:0];
    wire wrGo = wrPend && !sysReset;
    wire wrPc = wrGo && regHit(wrIdx, rsfl_pkg::IDX_POWER_CONTROL);
    wire wrRs = wrGo && regHit(wrIdx, rsfl_pkg::IDX_RESET_STATUS);
    wire wrCc = wrGo && regHit(wrIdx, rsfl_pkg::IDX_CHIP_CONTROL);
    wire wrWd = wrGo && regHit(wrIdx, rsfl_pkg::IDX_WATCHDOG_CONTROL);
    wire wrPm = wrGo && regHit(wrIdx, rsfl_pkg::IDX_POWER_MONITOR);
    wire wrIm = wrPend && regHit(wrIdx, rsfl_pkg::IDX_IRQ_MASK);
    wire rdIrqClr = rdTake && regHit(addrIdx, rsfl_pkg::IDX_IRQ_STATUS);

    wire [7:0] pcRead = {serialBaudDoubler, 2'h0, coldResetFlag,
                         generalFlagOne, generalFlagZero, 2'h0};
    wire [7:0] rsRead = {5'h00, brownoutResetCauseFlag, 1'b0,
                         softResetCauseFlag};
    wire [7:0] ccRead = {softResetTrigger, 7'h00};
    wire [7:0] wdRead = {watchdogRunEnable, 1'b0, 1'b0, watchdogInPowerdown,
                         watchdogResetCauseFlag, watchdogPrescale};
    wire [7:0] pmRead = {3'h0, brownoutResetEnable, 4'h0};
    logic [7:0] rdByte;

    always_comb begin
        if (!addrOk) begin
            rdByte = 8'h00;
        end else if (regHit(addrIdx, rsfl_pkg::IDX_POWER_CONTROL)) begin
            rdByte = pcRead;
        end else if (regHit(addrIdx, rsfl_pkg::IDX_RESET_STATUS)) begin
            rdByte = rsRead;
        end else if (regHit(addrIdx, rsfl_pkg::IDX_CHIP_CONTROL)) begin
            rdByte = ccRead;
        end else if (regHit(addrIdx, rsfl_pkg::IDX_WATCHDOG_CONTROL)) begin
            rdByte = wdRead;
        end else if (regHit(addrIdx, rsfl_pkg::IDX_POWER_MONITOR)) begin
            rdByte = pmRead;
        end else if (regHit(addrIdx, rsfl_pkg::IDX_IRQ_STATUS)) begin
            rdByte = {3'h0, irqStatus};
        end else if (regHit(addrIdx, rsfl_pkg::IDX_IRQ_MASK)) begin
            rdByte = {3'h0, irqMask};
        end else begin
            rdByte = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wrPend <= 1'b0;
            wrIdx <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend <= take && hwrite && addrOk;
            if (take) begin
                wrIdx <= addrIdx;
            end
            if (rdTake) begin
                hrdata <= {24'h000000, rdByte};
            end
        end
    end

    // [R2] Control bits return to reset values on every system reset
    always_ff @(posedge core_clk) begin
        if (rst || sysReset) begin
            serialBaudDoubler <= 1'b0;
            generalFlagOne <= 1'b0;
            generalFlagZero <= 1'b0;
            watchdogRunEnable <= 1'b0;
            watchdogInPowerdown <= 1'b0;
            watchdogPrescale <= rsfl_pkg::WATCHDOG_PRESCALE_RST;
            brownoutResetEnable <= rsfl_pkg::BROWNOUT_RESET_ENABLE_RST;
            watchdogClear <= 1'b0;
        end else begin
            watchdogClear <= wrWd && wrData[rsfl_pkg::WATCHDOG_CLEAR_BIT];
            if (wrPc) begin
                serialBaudDoubler <= wrData[rsfl_pkg::SERIAL_BAUD_DOUBLER_BIT];
                generalFlagOne <= wrData[rsfl_pkg::GENERAL_FLAG_ONE_BIT];
                generalFlagZero <= wrData[rsfl_pkg::GENERAL_FLAG_ZERO_BIT];
            end
            if (wrWd) begin
                watchdogRunEnable <= wrData[rsfl_pkg::WATCHDOG_RUN_ENABLE_BIT];
                watchdogInPowerdown <=
                    wrData[rsfl_pkg::WATCHDOG_IN_POWERDOWN_BIT];
                watchdogPrescale <= wrData[rsfl_pkg::WATCHDOG_PRESCALE_MSB:0];
            end
            if (wrPm) begin
                brownoutResetEnable <=
                    wrData[rsfl_pkg::BROWNOUT_RESET_ENABLE_BIT];
            end
        end
    end

    // [R18] Trigger stays until its reset finishes
    always_ff @(posedge core_clk) begin
        if (rst || inPowerOn) begin
            softResetTrigger <= 1'b0;
        end else if (softResetTrigger && leavingReset) begin
            softResetTrigger <= 1'b0;
        end else if (wrCc && wrData[rsfl_pkg::SOFT_RESET_TRIGGER_BIT]) begin
            softResetTrigger <= 1'b1;
        end
    end

    // Cause flags: hardware set wins over a software write
    always_ff @(posedge core_clk) begin
        if (rst || inPowerOn) begin
            // [R17] Power-on clears the warm flags
            brownoutResetCauseFlag <= 1'b0;
            softResetCauseFlag <= 1'b0;
            watchdogResetCauseFlag <= 1'b0;
        end else begin
            // [R5] Brown-out flag set, [R6] cleared by write
            if (borEvt) begin
                brownoutResetCauseFlag <= 1'b1;
            end else if (wrRs) begin
                brownoutResetCauseFlag <=
                    wrData[rsfl_pkg::BROWNOUT_RESET_CAUSE_FLAG_BIT];
            end
            // [R7] Soft flag set on software reset
            if (swEvt) begin
                softResetCauseFlag <= 1'b1;
            end else if (wrRs) begin
                softResetCauseFlag <=
                    wrData[rsfl_pkg::SOFT_RESET_CAUSE_FLAG_BIT];
            end
            // [R8] Watchdog flag set on time-out
            if (wdtEvt) begin
                watchdogResetCauseFlag <= 1'b1;
            end else if (wrWd) begin
                watchdogResetCauseFlag <=
                    wrData[rsfl_pkg::WATCHDOG_RESET_CAUSE_FLAG_BIT];
            end
        end
    end

    // [R3] Cold flag set on power-on completion; [R4] warm resets keep it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            coldResetFlag <= 1'b0;
        end else if (coldDone) begin
            coldResetFlag <= 1'b1;
        end else if (wrPc) begin
            // [R13] Software may clear it
            coldResetFlag <= wrData[rsfl_pkg::COLD_RESET_FLAG_BIT];
        end
    end

    // Interrupt status: set per event, cleared by reading, set wins
    logic [rsfl_pkg::IRQ_WIDTH-1:0] irqSet;
    always_comb begin
        irqSet = '0;
        irqSet[rsfl_pkg::IRQ_SOFT_BIT] = swEvt;
        irqSet[rsfl_pkg::IRQ_PIN_BIT] = pinEvt;
        irqSet[rsfl_pkg::IRQ_WATCHDOG_BIT] = wdtEvt;
        irqSet[rsfl_pkg::IRQ_BROWNOUT_BIT] = borEvt;
        irqSet[rsfl_pkg::IRQ_COLD_BIT] = coldDone;
    end

    wire [rsfl_pkg::IRQ_WIDTH-1:0] next_irqStatus =
        irqSet | (rdIrqClr ? '0 : irqStatus);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqStatus <= '0;
            irqMask <= rsfl_pkg::IRQ_MASK_RST;
            irq <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wrIm) begin
                irqMask <= wrData[rsfl_pkg::IRQ_WIDTH-1:0];
            end
            irq <= |(next_irqStatus & (wrIm ?
                wrData[rsfl_pkg::IRQ_WIDTH-1:0] : irqMask));
        end
    end

    // [R14] No memory here is cleared on power-on; RAM stays untouched
endmodule

// file: test/rsfl_reset_flags_asserts.sv
// Checker for the reset source and cause flag block, bound to its top.
// Assumes one core_clk domain with synchronous active-high rst.
`timescale 1ns/1ps
module rsfl_reset_flags_asserts (
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Bus answers
    input logic hreadyout,
    input logic hresp,
    input logic [31:0] hrdata,
    // Reset sources
    input logic resetPin,
    input logic supplyBelowRef,
    input logic watchdogTimeout,
    // Towards the core
    input logic sysReset,
    input logic oscEnable,
    input logic [15:0] resetVector,
    input logic watchdogClear,
    input logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_supply_holds_core: assert property (
        supplyBelowRef [*8] |-> sysReset)
        else $error("core running while supply is low");
    a_pin_holds_core: assert property (
        resetPin [*8] |-> sysReset)
        else $error("core running while reset pin is high");
    // Two machine cycles of twelve clocks, counted in three runs of eight
    a_wd_reset_hold: assert property (
        watchdogTimeout && !sysReset |-> ##[1:3] sysReset [*8]
        ##1 sysReset [*8] ##1 sysReset [*8])
        else $error("watchdog reset missing or too short");
    a_run_needs_osc: assert property (
        !sysReset |-> oscEnable)
        else $error("core released before oscillator start");
    a_vector_on_exit: assert property (
        $fell(sysReset) |-> resetVector == 16'h0000)
        else $error("restart vector not zero at release");
    a_bus_ready: assert property (
        !$past(rst) |-> hreadyout && !hresp)
        else $error("bus not ready or error response");
    a_upper_bits_zero: assert property (
        hrdata[31:8] == 24'h000000)
        else $error("read data above low byte not zero");
    a_clear_one_pulse: assert property (
        watchdogClear |=> !watchdogClear)
        else $error("watchdog clear longer than one cycle");

    c_release: cover property ($fell(sysReset));
    c_irq: cover property ($rose(irq));
    c_wd: cover property (watchdogTimeout && !sysReset);
endmodule

bind rsfl_reset_flags rsfl_reset_flags_asserts u_chk (
    .core_clk, .rst, .hreadyout, .hresp, .hrdata, .resetPin,
    .supplyBelowRef, .watchdogTimeout, .sysReset, .oscEnable,
    .resetVector, .watchdogClear, .irq
);

// file: test/rsfl_core_model.sv
// Processor-side model: measures how long each system reset stands.
// Assumes sysReset is a core_clk level from the block.
`timescale 1ns/1ps
module rsfl_core_model (
    // Clock
    input logic core_clk,
    // Reset from the block
    input logic sysReset,
    // Clocks the last reset pulse stood
    output logic [7:0] holdLen
);
    logic [7:0] runLen = 8'h00;

    initial holdLen = 8'h00;
    // The core fetches nothing while held, so it only counts
    always @(posedge core_clk) begin
        if (sysReset) begin
            runLen <= runLen + 8'h01;
        end else if (runLen != 8'h00) begin
            holdLen <= runLen;
            runLen <= 8'h00;
        end
    end
endmodule

// file: test/rsfl_reset_flags_tb.sv
// Self-checking bench for the reset source and cause flag block.
// Assumes a zero-wait AHB-Lite slave and the register map of rsfl_pkg.
`timescale 1ns/1ps
module rsfl_reset_flags_tb;
    localparam logic [7:0] PWR = rsfl_pkg::IDX_POWER_CONTROL;
    localparam logic [7:0] RSTS = rsfl_pkg::IDX_RESET_STATUS;
    localparam logic [7:0] CHIP = rsfl_pkg::IDX_CHIP_CONTROL;
    localparam logic [7:0] WDOG = rsfl_pkg::IDX_WATCHDOG_CONTROL;
    localparam logic [7:0] PMON = rsfl_pkg::IDX_POWER_MONITOR;
    localparam logic [7:0] IQS = rsfl_pkg::IDX_IRQ_STATUS;
    localparam logic [7:0] IQM = rsfl_pkg::IDX_IRQ_MASK;
    logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rnd;
    logic [1:0] htrans = 2'h0;
    logic resetPin = 1'b0, supplyBelowRef = 1'b0, brownoutDetect = 1'b0;
    logic watchdogTimeout = 1'b0, rdPend = 1'b0;
    logic hreadyout, hresp, sysReset, oscEnable, irq;
    logic serialBaudDoubler, watchdogRunEnable, watchdogInPowerdown;
    logic watchdogClear;
    logic [2:0] watchdogPrescale;
    // Watchdog outputs laid out as the watchdog_control byte
    wire [7:0] wdOut = {watchdogRunEnable, watchdogClear, 1'b0,
                        watchdogInPowerdown, 1'b0, watchdogPrescale};
    logic [15:0] resetVector;
    logic [7:0] holdLen;
    logic [31:0] expQ[$];
    int n_errors = 0, comparisons = 0, cycles = 0;

    rsfl_reset_flags u_dut (
        .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .resetPin, .supplyBelowRef, .brownoutDetect, .watchdogTimeout,
        .sysReset, .oscEnable, .resetVector, .watchdogRunEnable,
        .watchdogInPowerdown, .watchdogPrescale, .watchdogClear,
        .serialBaudDoubler, .irq
    );
    rsfl_core_model u_core (.core_clk, .sysReset, .holdLen);

    always #5 core_clk = ~core_clk;

    task automatic summarize();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Address phase held until ready, then the data phase likewise
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] val);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        if (!wr) expQ.push_back(val);
        htrans <= 2'h0;
        hwdata <= wr ? val : 32'h0;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic waitRun(input int lead);
        repeat (lead) @(posedge core_clk);
        while (sysReset !== 1'b0) @(posedge core_clk);
        @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (rdPend && hreadyout === 1'b1 && expQ.size() > 0) begin
            check(hrdata, expQ.pop_front());
        end
        rdPend <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        rnd = $urandom(71220);
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        waitRun(2);
        xfer(0, PWR, 32'h10);
        check({16'h0, resetVector}, 32'h0);
        xfer(0, RSTS, 32'h0);
        xfer(0, PMON, 32'h10);
        rnd = $urandom & 32'h8C;
        xfer(1, PWR, rnd);
        // Port settles one edge after the write lands
        @(posedge core_clk);
        check({31'h0, serialBaudDoubler}, {31'h0, rnd[7]});
        xfer(0, PWR, rnd);
        xfer(1, PWR, 32'h0);
        rnd = $urandom & 32'h97;
        xfer(1, WDOG, rnd | 32'h40);
        @(posedge core_clk);
        check({24'h0, wdOut}, rnd | 32'h40);
        xfer(0, WDOG, rnd);
        watchdogTimeout <= 1'b1;
        @(posedge core_clk);
        watchdogTimeout <= 1'b0;
        waitRun(3);
        check(holdLen, 8'h18);
        check({24'h0, wdOut}, 32'h0);
        xfer(0, WDOG, 32'h08);
        xfer(0, PWR, 32'h0);
        xfer(1, CHIP, 32'h80);
        waitRun(4);
        check(holdLen, 8'h18);
        xfer(0, RSTS, 32'h01);
        xfer(0, CHIP, 32'h0);
        xfer(0, WDOG, 32'h08);
        brownoutDetect <= 1'b1;
        repeat (12) @(posedge core_clk);
        brownoutDetect <= 1'b0;
        waitRun(2);
        xfer(0, RSTS, 32'h05);
        xfer(1, PMON, 32'h0);
        brownoutDetect <= 1'b1;
        repeat (12) @(posedge core_clk);
        check({31'h0, sysReset}, 32'h0);
        brownoutDetect <= 1'b0;
        xfer(0, RSTS, 32'h05);
        xfer(1, RSTS, 32'h0);
        xfer(0, RSTS, 32'h0);
        check({31'h0, irq}, 32'h0);
        xfer(0, IQS, 32'h1D);
        xfer(1, IQM, 32'h02);
        // Pin held beyond two machine cycles
        resetPin <= 1'b1;
        repeat (30 + ($urandom % 16)) @(posedge core_clk);
        resetPin <= 1'b0;
        waitRun(2);
        check({31'h0, irq}, 32'h1);
        xfer(0, RSTS, 32'h0);
        xfer(0, IQS, 32'h02);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        xfer(1, RSTS, 32'h05);
        supplyBelowRef <= 1'b1;
        repeat (40) @(posedge core_clk);
        check({31'h0, sysReset}, 32'h1);
        supplyBelowRef <= 1'b0;
        waitRun(2);
        xfer(0, PWR, 32'h10);
        xfer(0, RSTS, 32'h0);
        xfer(0, WDOG, 32'h0);
        repeat (2) @(posedge core_clk);
        summarize();
    end
endmodule
